// file: core/rice_pkg.sv
// package: codes, sizes, carriers and checksum helpers of the command engine
package rice_pkg;
	localparam int CLK_HZ = 10000000; // system clock rate
	localparam int BUS_HZ = 100000; // two-wire bit rate
	localparam int QTR_CYC = CLK_HZ / (4 * BUS_HZ); // cycles per quarter bit
	localparam int PKT_MAX = 180; // largest request or reply, bytes
	localparam int HDR_LEN = 6; // code, tag and length
	localparam int CKS_LEN = 2; // trailing checksum
	localparam int RD_MAX_B = 16; // widest register value read
	localparam int WR_MAX_B = 8; // widest register value written
	// function codes
	localparam logic [15:0] FC_RD_REQ = 16'h0021;
	localparam logic [15:0] FC_WR_REQ = 16'h0022;
	localparam logic [15:0] FC_RD_ANS = 16'h0023;
	localparam logic [15:0] FC_WR_ANS = 16'h0024;
	localparam logic [15:0] FC_BUS_REQ = 16'h0007;
	localparam logic [15:0] FC_BUS_ANS = 16'h0008;
	// acknowledge-status byte layout
	localparam int ACK_ADDR_W = 0;
	localparam int ACK_DATA_W = 1;
	localparam int ACK_ADDR_R = 2;
	localparam logic [7:0] ACK_INIT = 8'h80; // bit 7 always one
	// two-wire byte engine operations
	typedef enum logic [1:0] {TW_START, TW_STOP, TW_WRITE, TW_READ} rice_twop_t;
	typedef struct packed {
		rice_twop_t op;
		logic [7:0] wdata;
		logic nack; // read: release ack slot
	} rice_twcmd_t;
	// one byte of a packet stream
	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} rice_byte_t;
	// add one byte, complemented, to the running sum; hi selects the word half
	function automatic logic [31:0] rice_cks_add(input logic [31:0] acc,
		input logic [7:0] b, input logic hi);
		return acc + (hi ? {16'h0000, ~b, 8'h00} : {24'h00_0000, ~b});
	endfunction : rice_cks_add
	// pad an odd tail with a zero low byte, then fold the carries twice
	function automatic logic [15:0] rice_cks_fold(input logic [31:0] acc, input logic odd);
		logic [31:0] s;
		logic [16:0] t;
		s = acc + (odd ? 32'h0000_00FF : 32'h0000_0000);
		t = {1'b0, s[31:16]} + {1'b0, s[15:0]};
		return t[15:0] + {15'h0000, t[16]};
	endfunction : rice_cks_fold
endpackage : rice_pkg

// file: core/rice_twi.sv
// two-wire bus byte engine: start, stop, byte write and byte read
`timescale 1ns/1ps
module rice_twi (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// command side
	input wire logic go,
	input wire rice_pkg::rice_twcmd_t cmd,
	output logic done,
	output logic [7:0] rd_byte,
	output logic ack,
	// open-drain pins, enable low while pulling low
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n
);
	import rice_pkg::*;
	logic scl_m_r, scl_s_r, sda_m_r, sda_s_r; // pin synchronisers
	logic [15:0] qcnt_r; // quarter-bit divider
	logic [1:0] q_r; // quarter within a bit
	logic [3:0] bi_r; // bit index, 8 is the ack slot
	logic busy_r;
	rice_twcmd_t cur_r;
	logic tick, adv, bitv;
	// two flops on each pin before anything looks at it
	always_ff @(posedge clk_sys) begin
		scl_m_r <= scl_i;
		scl_s_r <= scl_m_r;
		sda_m_r <= sda_i;
		sda_s_r <= sda_m_r;
	end
	assign tick = busy_r && (qcnt_r == 16'(QTR_CYC - 1));
	// a slave holding the clock low stretches the high quarter
	assign adv = tick && !(q_r == 2'd2 && scl_oe_n && !scl_s_r);
	// bit to put on the data line in quarter 0
	assign bitv = (bi_r < 4'd8) ?
		((cur_r.op == TW_WRITE) ? cur_r.wdata[3'(4'd7 - bi_r)] : 1'b1) :
		((cur_r.op == TW_WRITE) ? 1'b1 : cur_r.nack);
	// divider restarts for every quarter
	always_ff @(posedge clk_sys) begin
		if (rst || !busy_r || tick) begin
			qcnt_r <= 16'h0000;
		end else begin
			qcnt_r <= qcnt_r + 16'h0001;
		end
	end
	// sequencer: each operation walks its quarters, bytes walk nine bits
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busy_r <= 1'b0;
			done <= 1'b0;
			q_r <= 2'd0;
			bi_r <= 4'h0;
			cur_r <= '0;
			rd_byte <= 8'h00;
			ack <= 1'b0;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			done <= 1'b0;
			if (go && !busy_r) begin
				busy_r <= 1'b1;
				cur_r <= cmd;
				q_r <= 2'd0;
				bi_r <= 4'h0;
			end else if (adv) begin
				q_r <= q_r + 2'd1;
				case (cur_r.op)
					TW_START: begin
						// release both, then data falls while clock is high
						case (q_r)
							2'd0: begin
								sda_oe_n <= 1'b1;
								scl_oe_n <= 1'b1;
							end
							2'd2: sda_oe_n <= 1'b0;
							2'd3: begin
								scl_oe_n <= 1'b0;
								busy_r <= 1'b0;
								done <= 1'b1;
							end
							default: ;
						endcase
					end
					TW_STOP: begin
						// data rises while clock is high
						case (q_r)
							2'd0: sda_oe_n <= 1'b0;
							2'd1: scl_oe_n <= 1'b1;
							2'd3: begin
								sda_oe_n <= 1'b1;
								busy_r <= 1'b0;
								done <= 1'b1;
							end
							default: ;
						endcase
					end
					default: begin
						// one bit per four quarters, sampled at clock high
						case (q_r)
							2'd0: sda_oe_n <= bitv;
							2'd1: scl_oe_n <= 1'b1;
							2'd2: begin
								if (bi_r < 4'd8) begin
									rd_byte <= {rd_byte[6:0], sda_s_r};
								end else begin
									ack <= !sda_s_r;
								end
							end
							default: begin
								scl_oe_n <= 1'b0;
								bi_r <= bi_r + 4'h1;
								if (bi_r == 4'd8) begin
									busy_r <= 1'b0;
									done <= 1'b1;
								end
							end
						endcase
					end
				endcase
			end
		end
	end
endmodule : rice_twi

// file: core/rice_top.sv
// command engine: register read/write and two-wire transfer packets
`timescale 1ns/1ps
module rice_top (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// request stream, last marks the transport packet end
	input wire rice_pkg::rice_byte_t in_byte,
	output logic in_ready,
	// reply stream
	output rice_pkg::rice_byte_t out_byte,
	input wire logic out_ready,
	// parameter register map, value width in bytes for reg_addr
	output logic [7:0] reg_addr,
	output logic reg_rd_en,
	input wire logic [127:0] reg_rd_data,
	input wire logic [4:0] reg_len,
	output logic reg_wr_en,
	output logic [63:0] reg_wr_data,
	// status
	output logic pkt_drop,
	// two-wire bus pins
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n
);
	import rice_pkg::*;
	typedef enum {S_RX, S_CHK, S_DISP, S_RD_A, S_RD_W, S_RD_V, S_WR_A, S_WR_L, S_WR_D,
		S_WR_E, S_B_H, S_B_WS, S_B_WA, S_B_WD, S_B_Y, S_B_RS, S_B_RA, S_B_RD, S_B_SP,
		S_B_ST, S_TX} rice_state_t;
	rice_state_t state_r;
	logic [7:0] rx_mem [0:PKT_MAX-1]; // whole request is held before it runs
	logic [7:0] tx_mem [0:PKT_MAX-1]; // reply body from offset 6
	logic [7:0] rx_cnt_r, ci_r, rp_r, wp_r, ti_r, cnt_r, y_r, ack_r;
	logic [6:0] sla_r; // slave address of the current group
	logic rx_ovf_r;
	logic [31:0] acc_r; // running checksum sum
	logic [15:0] fc_r, code_r;
	logic [127:0] rd_val_r;
	logic tw_go_r, tw_wait_r, tw_need, tw_done, tw_ack;
	logic [7:0] tw_rd;
	rice_twcmd_t tw_cmd;
	logic [7:0] end_w, txb;
	logic [15:0] len_w, rx_cks, cks_w;
	logic cks_ok;
	assign end_w = rx_cnt_r - 8'(CKS_LEN); // first checksum byte
	assign rx_cks = {rx_mem[end_w], rx_mem[end_w + 8'h01]};
	assign cks_ok = rice_cks_fold(acc_r, rx_cnt_r[0]) == rx_cks;
	assign len_w = (fc_r == FC_WR_REQ) ? 16'h0000 : {8'h00, wp_r - 8'(HDR_LEN)};
	assign cks_w = rice_cks_fold(acc_r, wp_r[0]);
	// reply byte at ti_r: header high byte first, body, checksum
	always_comb begin
		case (ti_r)
			8'd0: txb = code_r[15:8];
			8'd1: txb = code_r[7:0];
			8'd2: txb = rx_mem[2];
			8'd3: txb = rx_mem[3];
			8'd4: txb = len_w[15:8];
			8'd5: txb = len_w[7:0];
			default: txb = (ti_r < wp_r) ? tx_mem[ti_r] :
				(ti_r == wp_r) ? cks_w[15:8] : cks_w[7:0];
		endcase
	end
	// bus states ask the byte engine for one operation each
	always_comb begin
		tw_need = 1'b1;
		tw_cmd = '{op: TW_STOP, wdata: 8'h00, nack: 1'b0};
		case (state_r)
			S_B_WS, S_B_RS: tw_cmd.op = TW_START;
			S_B_WA: tw_cmd = '{op: TW_WRITE, wdata: {sla_r, 1'b0}, nack: 1'b0};
			S_B_WD: tw_cmd = '{op: TW_WRITE, wdata: rx_mem[rp_r], nack: 1'b0};
			S_B_RA: tw_cmd = '{op: TW_WRITE, wdata: {sla_r, 1'b1}, nack: 1'b0};
			S_B_RD: tw_cmd = '{op: TW_READ, wdata: 8'h00, nack: cnt_r == 8'd1};
			S_B_SP: tw_cmd.op = TW_STOP;
			default: tw_need = 1'b0;
		endcase
	end
	// issue once per operation, again after each finish while the state asks, wait for the engine to finish
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tw_go_r <= 1'b0;
			tw_wait_r <= 1'b0;
		end else begin
			tw_go_r <= tw_need && !tw_wait_r && !tw_go_r;
			if (tw_go_r) begin
				tw_wait_r <= 1'b1;
			end else if (tw_done) begin
				tw_wait_r <= 1'b0;
			end
		end
	end
	rice_twi u_twi (
		.clk_sys(clk_sys),
		.rst(rst),
		.go(tw_go_r),
		.cmd(tw_cmd),
		.done(tw_done),
		.rd_byte(tw_rd),
		.ack(tw_ack),
		.scl_i(scl_i),
		.scl_o(scl_o),
		.scl_oe_n(scl_oe_n),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe_n(sda_oe_n)
	);
	// request capture; bytes past the buffer only mark the packet bad
	always_ff @(posedge clk_sys) begin
		if (in_ready && in_byte.valid && rx_cnt_r < 8'(PKT_MAX)) begin
			rx_mem[rx_cnt_r] <= in_byte.data;
		end
	end
	// main sequencer: receive, check, execute, reply
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= S_RX;
			in_ready <= 1'b0;
			out_byte <= '0;
			reg_addr <= 8'h00;
			reg_rd_en <= 1'b0;
			reg_wr_en <= 1'b0;
			reg_wr_data <= 64'h0000_0000_0000_0000;
			pkt_drop <= 1'b0;
			{rx_cnt_r, ci_r, rp_r, wp_r, ti_r, cnt_r, y_r, ack_r} <= '0;
			{sla_r, rx_ovf_r, acc_r, fc_r, code_r, rd_val_r} <= '0;
		end else begin
			reg_rd_en <= 1'b0;
			reg_wr_en <= 1'b0;
			pkt_drop <= 1'b0;
			case (state_r)
				S_RX: begin
					in_ready <= 1'b1;
					if (in_ready && in_byte.valid) begin
						if (rx_cnt_r < 8'(PKT_MAX)) begin
							rx_cnt_r <= rx_cnt_r + 8'h01;
						end else begin
							rx_ovf_r <= 1'b1;
						end
						if (in_byte.last) begin
							in_ready <= 1'b0;
							state_r <= S_CHK;
							ci_r <= 8'h00;
							acc_r <= 32'h0000_0000;
						end
					end
				end
				S_CHK: begin
					// one byte per cycle, then judge the whole packet
					if (rx_cnt_r < 8'(HDR_LEN + CKS_LEN) || rx_ovf_r) begin
						state_r <= S_DISP;
					end else if (ci_r != end_w) begin
						acc_r <= rice_cks_add(acc_r, rx_mem[ci_r], !ci_r[0]);
						ci_r <= ci_r + 8'h01;
					end else begin
						state_r <= S_DISP;
					end
					fc_r <= {rx_mem[0], rx_mem[1]};
				end
				S_DISP: begin
					rp_r <= 8'(HDR_LEN);
					wp_r <= 8'(HDR_LEN);
					acc_r <= 32'h0000_0000; // reply checksum starts afresh
					ti_r <= 8'h00;
					// length must close exactly on this packet
					if (rx_ovf_r || rx_cnt_r < 8'(HDR_LEN + CKS_LEN) || !cks_ok ||
						{rx_mem[4], rx_mem[5]} != {8'h00, end_w - 8'(HDR_LEN)}) begin
						pkt_drop <= 1'b1;
						// a dropped packet must not leave bytes for the next one
						rx_cnt_r <= 8'h00;
						rx_ovf_r <= 1'b0;
						state_r <= S_RX;
					end else if (fc_r == FC_RD_REQ) begin
						code_r <= FC_RD_ANS;
						state_r <= S_RD_A;
					end else if (fc_r == FC_WR_REQ) begin
						code_r <= FC_WR_ANS;
						state_r <= S_WR_A;
					end else if (fc_r == FC_BUS_REQ) begin
						code_r <= FC_BUS_ANS;
						state_r <= S_B_H;
					end else begin
						pkt_drop <= 1'b1;
						rx_cnt_r <= 8'h00;
						rx_ovf_r <= 1'b0;
						state_r <= S_RX;
					end
				end
				S_RD_A: begin
					if (rp_r >= end_w) begin
						state_r <= S_TX;
					end else begin
						reg_addr <= rx_mem[rp_r];
						reg_rd_en <= 1'b1;
						rp_r <= rp_r + 8'h01;
						state_r <= S_RD_W;
					end
				end
				S_RD_W: begin
					// stop before a pair that would push the reply past the cap
					if ({3'h0, wp_r} + 11'd1 + {6'h00, reg_len} + 11'(CKS_LEN) >
						11'(PKT_MAX) || reg_len == 5'd0 || reg_len > 5'(RD_MAX_B)) begin
						state_r <= S_TX;
					end else begin
						tx_mem[wp_r] <= reg_addr;
						wp_r <= wp_r + 8'h01;
						rd_val_r <= reg_rd_data;
						cnt_r <= {3'h0, reg_len};
						state_r <= S_RD_V;
					end
				end
				S_RD_V: begin
					tx_mem[wp_r] <= rd_val_r[{cnt_r[3:0] - 4'h1, 3'h0} +: 8];
					wp_r <= wp_r + 8'h01;
					cnt_r <= cnt_r - 8'h01;
					if (cnt_r == 8'd1) begin
						state_r <= S_RD_A;
					end
				end
				S_WR_A: begin
					if (rp_r >= end_w) begin
						state_r <= S_TX;
					end else begin
						reg_addr <= rx_mem[rp_r];
						rp_r <= rp_r + 8'h01;
						state_r <= S_WR_L;
					end
				end
				S_WR_L: begin
					// values wider than the write path are cut to its width
					cnt_r <= (reg_len > 5'(WR_MAX_B)) ? 8'(WR_MAX_B) : {3'h0, reg_len};
					reg_wr_data <= 64'h0000_0000_0000_0000;
					state_r <= (reg_len == 5'd0) ? S_WR_A : S_WR_D;
				end
				S_WR_D: begin
					if (rp_r >= end_w) begin
						state_r <= S_TX; // truncated pair is not written
					end else begin
						reg_wr_data <= {reg_wr_data[55:0], rx_mem[rp_r]};
						rp_r <= rp_r + 8'h01;
						cnt_r <= cnt_r - 8'h01;
						if (cnt_r == 8'd1) begin
							state_r <= S_WR_E;
						end
					end
				end
				S_WR_E: begin
					reg_wr_en <= 1'b1;
					state_r <= S_WR_A;
				end
				S_B_H: begin
					// next group, or reply when the parameters run out
					if (rp_r + 8'h01 >= end_w) begin
						state_r <= S_TX;
					end else begin
						sla_r <= rx_mem[rp_r][6:0];
						cnt_r <= rx_mem[rp_r + 8'h01];
						y_r <= rx_mem[rp_r + 8'h01]; // write count, until the read count
						rp_r <= rp_r + 8'h02;
						ack_r <= ACK_INIT;
						state_r <= (rx_mem[rp_r + 8'h01] == 8'h00) ? S_B_Y : S_B_WS;
					end
				end
				S_B_WS: if (tw_done) state_r <= S_B_WA;
				S_B_WA: begin
					if (tw_done) begin
						ack_r[ACK_ADDR_W] <= tw_ack;
						ack_r[ACK_DATA_W] <= 1'b1;
						state_r <= S_B_WD;
					end
				end
				S_B_WD: begin
					if (tw_done) begin
						ack_r[ACK_DATA_W] <= ack_r[ACK_DATA_W] & tw_ack;
						rp_r <= rp_r + 8'h01;
						cnt_r <= cnt_r - 8'h01;
						if (cnt_r == 8'd1) begin
							state_r <= S_B_Y;
						end
					end
				end
				S_B_Y: begin
					y_r <= rx_mem[rp_r];
					rp_r <= rp_r + 8'h01;
					if (rx_mem[rp_r] != 8'h00) begin
						state_r <= S_B_RS;
					end else begin
						// both counts zero: no bus traffic at all
						state_r <= (y_r == 8'h00) ? S_B_ST : S_B_SP;
					end
				end
				S_B_RS: if (tw_done) state_r <= S_B_RA;
				S_B_RA: begin
					if (tw_done) begin
						ack_r[ACK_ADDR_R] <= tw_ack;
						cnt_r <= y_r;
						state_r <= S_B_RD;
					end
				end
				S_B_RD: begin
					if (tw_done) begin
						if (wp_r < 8'(PKT_MAX - CKS_LEN - 1)) begin
							tx_mem[wp_r] <= tw_rd;
							wp_r <= wp_r + 8'h01;
						end
						cnt_r <= cnt_r - 8'h01;
						if (cnt_r == 8'd1) begin
							state_r <= S_B_SP;
						end
					end
				end
				S_B_SP: if (tw_done) state_r <= S_B_ST;
				S_B_ST: begin
					if (wp_r < 8'(PKT_MAX - CKS_LEN)) begin
						tx_mem[wp_r] <= ack_r;
						wp_r <= wp_r + 8'h01;
					end
					state_r <= S_B_H;
				end
				S_TX: begin
					// every accepted command gets its reply here
					if (!out_byte.valid || out_ready) begin
						if (ti_r == wp_r + 8'h02) begin
							out_byte <= '0;
							ti_r <= 8'h00;
							rx_cnt_r <= 8'h00;
							rx_ovf_r <= 1'b0;
							state_r <= S_RX;
						end else begin
							out_byte <= '{valid: 1'b1, last: ti_r == wp_r + 8'h01, data: txb};
							if (ti_r < wp_r) begin
								acc_r <= rice_cks_add(acc_r, txb, !ti_r[0]);
							end
							ti_r <= ti_r + 8'h01;
						end
					end
				end
				default: state_r <= S_RX;
			endcase
		end
	end
	// checks on the sequencer
	chk_reply_cap: assert property (@(posedge clk_sys) disable iff (rst)
		wp_r <= 8'(PKT_MAX - CKS_LEN)) else $error("reply body over cap");
	chk_status_fixed: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == S_B_ST |-> ack_r[7] && ack_r[6:3] == 4'h0) else $error("bad status");
	chk_wr_len_zero: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == S_TX && code_r == FC_WR_ANS |-> len_w == 16'h0000)
		else $error("write reply length not zero");
	chk_rd_code: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == S_TX && fc_r == FC_RD_REQ |-> code_r == FC_RD_ANS)
		else $error("read reply code wrong");
	chk_bus_code: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == S_TX && fc_r == FC_BUS_REQ |-> code_r == FC_BUS_ANS)
		else $error("transfer reply code wrong");
	chk_bad_drop: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == S_DISP && !cks_ok |=> pkt_drop && state_r == S_RX)
		else $error("bad checksum not dropped");
	chk_addr_w_ack: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == S_B_WA && tw_done |=> ack_r[ACK_ADDR_W] == $past(tw_ack))
		else $error("address ack not kept");
	chk_no_write_x0: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(state_r == S_B_Y) && $past(state_r) == S_B_H |-> ack_r == ACK_INIT)
		else $error("write phase ran for zero count");
	chk_hdr_tag: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == S_TX && out_byte.valid && ti_r == 8'd4 |-> out_byte.data == rx_mem[3])
		else $error("tag not echoed");
	cov_rd_reply: cover property (@(posedge clk_sys) state_r == S_TX && code_r == FC_RD_ANS);
	cov_wr_reply: cover property (@(posedge clk_sys) state_r == S_TX && code_r == FC_WR_ANS);
	cov_rd_after_wr: cover property (@(posedge clk_sys) state_r == S_B_RS && ack_r[1]);
	cov_drop: cover property (@(posedge clk_sys) pkt_drop);
endmodule : rice_top

// file: dv/rice_slave.sv
// two-wire slave model: byte store, first written byte sets the pointer
`timescale 1ns/1ps
module rice_slave #(
	parameter logic [6:0] ADDR = 7'h28 // bus address answered
) (
	// wire levels
	input wire logic scl,
	input wire logic sda,
	// refuse written data bytes while set
	input wire logic refuse_data,
	// low pulls sda low
	output logic sda_oe_n
);
	logic [7:0] mem [256]; // byte store
	logic [7:0] ptr; // access pointer
	logic [7:0] sh; // shift register, rotates while reading out
	int bitn; // clocks done in this byte
	logic hdr; // next byte is the address byte
	logic sel; // addressed
	logic rd; // read direction
	logic idx; // pointer byte still to come
	logic more; // master acked the last read byte
	initial begin
		sda_oe_n = 1'b1;
		{hdr, sel, rd, idx, more} = 5'h00;
		bitn = -1;
		for (int i = 0; i < 256; i++) mem[i] = 8'(i + 48);
	end
	// start or stop: sda moves while scl high
	always @(sda) begin
		if (scl === 1'b1) begin
			hdr = ~sda;
			sel = 1'b0;
			bitn = -1;
			sda_oe_n = 1'b1;
		end
	end
	// sample data bits, then the master's ack slot
	always @(posedge scl) begin
		if (bitn < 8) sh = {sh[6:0], sda};
		else more = ~sda;
	end
	// change sda only while scl is low
	always @(negedge scl) begin
		bitn++;
		sda_oe_n = 1'b1;
		if (bitn == 9) bitn = 0;
		if (bitn == 8) begin
			if (hdr) begin
				sel = (sh[7:1] == ADDR);
				rd = sh[0];
				idx = 1'b1;
				sda_oe_n = ~sel;
			end else if (sel && !rd) begin
				if (idx) ptr = sh;
				else begin
					mem[ptr] = sh;
					ptr++;
				end
				idx = 1'b0;
				sda_oe_n = refuse_data;
			end
			hdr = 1'b0;
		end else if (sel && rd && more) begin
			if (bitn == 0) begin
				sh = mem[ptr];
				ptr++;
			end
			sda_oe_n = sh[7];
		end
	end
endmodule : rice_slave

// file: dv/rice_top_tb.sv
// self-checking bench of the command engine
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module rice_top_tb;
	import rice_pkg::*;
	typedef logic [7:0] rice_bq_t [$]; // byte queue
	logic clk_sys, rst, in_ready, out_ready, reg_rd_en, reg_wr_en, pkt_drop;
	rice_byte_t in_byte, out_byte;
	logic [7:0] reg_addr;
	logic [127:0] reg_rd_data;
	logic [4:0] reg_len;
	logic [63:0] reg_wr_data;
	logic scl_o, scl_oe_n, sda_o, sda_oe_n, slv_oe_n, refuse_data, rx_done;
	wire logic scl_w, sda_w;
	rice_bq_t rx; // reply bytes taken
	logic [71:0] wr_log [$]; // {address, value} of register writes
	int n_errors, checks_done, drops, cyc, rd_seen;
	// open-drain wires with pull-ups
	assign scl_w = scl_oe_n | scl_o;
	assign sda_w = (sda_oe_n | sda_o) & slv_oe_n;
	rice_top dut (.clk_sys(clk_sys), .rst(rst), .in_byte(in_byte), .in_ready(in_ready),
		.out_byte(out_byte), .out_ready(out_ready), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en),
		.reg_rd_data(reg_rd_data), .reg_len(reg_len), .reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data), .pkt_drop(pkt_drop), .scl_i(scl_w), .scl_o(scl_o),
		.scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
	rice_slave slv (.scl(scl_w), .sda(sda_w), .refuse_data(refuse_data), .sda_oe_n(slv_oe_n));
	// register map: width a[3:0]+1 bytes, byte i holds a+i
	always_comb begin
		reg_len = 5'(reg_addr[3:0]) + 5'h01;
		for (int i = 0; i < 16; i++) reg_rd_data[8*i +: 8] = reg_addr + 8'(i);
	end
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// reply sink stalls one cycle in three so held bytes get tested
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		out_ready <= (cyc % 3 != 0);
		if (out_byte.valid === 1'b1 && out_ready === 1'b1) begin
			rx.push_back(out_byte.data);
			if (out_byte.last === 1'b1) rx_done = 1'b1;
		end
		if (reg_wr_en === 1'b1) wr_log.push_back({reg_addr, reg_wr_data});
		if (pkt_drop === 1'b1) drops++;
		if (reg_rd_en === 1'b1) rd_seen++;
	end
	// header, body, checksum; multi-byte fields high byte first
	function automatic rice_bq_t mk(input logic [15:0] code, tag, input rice_bq_t body);
		rice_bq_t p;
		logic [31:0] s;
		p = {};
		for (int i = 0; i < 6; i++) p.push_back(8'({code, tag, 16'(body.size())} >> (40 - 8*i)));
		p = {p, body};
		s = 32'h0000_0000;
		for (int i = 0; i < p.size(); i++) s += i[0] ? {24'h00_0000, ~p[i]} : {16'h0000, ~p[i], 8'h00};
		if (p.size() % 2) s += 32'h0000_00FF;
		s = {16'h0000, s[31:16]} + {16'h0000, s[15:0]};
		s = {16'h0000, s[31:16]} + {16'h0000, s[15:0]};
		p.push_back(s[15:8]);
		p.push_back(s[7:0]);
		return p;
	endfunction : mk
	// one transport packet, each byte held until taken
	task automatic put_pkt(input rice_bq_t p);
		@(posedge clk_sys);
		for (int i = 0; i < p.size(); i++) begin
			in_byte <= '{1'b1, i == p.size() - 1, p[i]};
			do @(posedge clk_sys); while (in_ready !== 1'b1);
		end
		in_byte <= '0;
	endtask : put_pkt
	// request, then compare the whole reply
	task automatic xfer(input rice_bq_t req, input rice_bq_t exp);
		rx = {};
		rx_done = 1'b0;
		put_pkt(req);
		wait (rx_done === 1'b1);
		@(posedge clk_sys);
		`CHK("reply length", exp.size(), rx.size())
		foreach (exp[i]) `CHK("reply byte", exp[i], rx[i])
	endtask : xfer
	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run
	// watchdog: the bus traffic needs some 12000 cycles
	initial begin
		#(40000 * 100);
		n_errors++;
		complete_run();
	end
	initial begin
		rice_bq_t q, e;
		rst = 1'b1;
		in_byte = '0;
		out_ready = 1'b0;
		refuse_data = 1'b0;
		rx_done = 1'b0;
		n_errors = 0;
		checks_done = 0;
		drops = 0;
		rd_seen = 0;
		cyc = 0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		// registers of two widths
		xfer(mk(FC_RD_REQ, 16'h1B34, '{8'h02, 8'h00}),
			mk(FC_RD_ANS, 16'h1B34, '{8'h02, 8'h04, 8'h03, 8'h02, 8'h00, 8'h00}));
		`CHK("register reads", 2, rd_seen)
		// thirty widest registers: only ten fit the reply
		q = {};
		repeat (30) q.push_back(8'h0F);
		e = {};
		repeat (10) begin
			e.push_back(8'h0F);
			for (int k = 15; k >= 0; k--) e.push_back(8'h0F + 8'(k));
		end
		xfer(mk(FC_RD_REQ, 16'h0002, q), mk(FC_RD_ANS, 16'h0002, e));
		e = {};
		xfer(mk(FC_WR_REQ, 16'h0003, '{8'h05, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66}),
			mk(FC_WR_ANS, 16'h0003, e));
		`CHK("write", 72'h05_0000_1122_3344_5566, wr_log.pop_front())
		// split request, bad checksum, unknown code: all silently dropped
		q = mk(FC_WR_REQ, 16'h0004, '{8'h05, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06});
		rx = {};
		put_pkt(q[0:6]);
		put_pkt(q[7:$]);
		q[14] = ~q[14];
		put_pkt(q);
		put_pkt(mk(16'h0099, 16'h0005, '{8'h00}));
		repeat (40) @(posedge clk_sys);
		`CHK("drops", 4, drops)
		`CHK("dropped replies", 0, rx.size())
		`CHK("dropped writes", 0, wr_log.size())
		// write, read after write, read of an absent slave
		q = '{8'h28, 8'h02, 8'h10, 8'hA5, 8'h00, 8'h28, 8'h01, 8'h10, 8'h02, 8'h33, 8'h00, 8'h01};
		xfer(mk(FC_BUS_REQ, 16'h1254, q),
			mk(FC_BUS_ANS, 16'h1254, '{8'h83, 8'hA5, 8'h41, 8'h87, 8'hFF, 8'h80}));
		// slave refuses data
		refuse_data <= 1'b1;
		xfer(mk(FC_BUS_REQ, 16'h1255, '{8'h28, 8'h01, 8'h20, 8'h00}),
			mk(FC_BUS_ANS, 16'h1255, '{8'h81}));
		`CHK("bus idle", 2'b11, {scl_w, sda_w})
		complete_run();
	end
endmodule : rice_top_tb
